// [bench/sdram_device_model.sv]
// behavioural memory die: refresh decode, self refresh, exit checks
module sdram_device_model #(
    parameter int EXIT_CYC = 6
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockRun,
    input wire logic cke,
    input wire logic csN,
    input wire logic [3:0] ca,
    output logic inSr,
    output logic [2:0] bankCnt,
    output int abCnt,
    output int pbCnt,
    output int viol
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ckeQ;
    logic [1:0] runQ;
    int exitQ;
    int intRef;

    // refresh happens only on commands or inside self refresh
    always @(posedge clock) begin
        if (rst) begin
            inSr <= 1'b0;
            bankCnt <= 3'h0;
            exitQ <= 0;
            abCnt <= 0;
            pbCnt <= 0;
            viol <= 0;
            intRef <= 0;
        end else if (inSr) begin
            if (cke) begin
                inSr <= 1'b0;
                exitQ <= EXIT_CYC;
                bankCnt <= 3'h0;
                if (runQ != 2'b11) viol <= viol + 1;
            end
        end else if (exitQ != 0) begin
            exitQ <= exitQ - 1;
            if (!cke || (!csN && ca != 4'h7)) viol <= viol + 1;
        end else if (!csN && ca[2:0] == 3'h4) begin
            if (!cke && ckeQ) begin
                inSr <= 1'b1;
                intRef <= intRef + 1;
            end else if (ca[3]) begin
                abCnt <= abCnt + 1;
                bankCnt <= 3'h0;
            end else begin
                pbCnt <= pbCnt + 1;
                bankCnt <= bankCnt + 3'h1;
            end
        end
        ckeQ <= cke;
        runQ <= {runQ[0], clockRun};
    end
endmodule : sdram_device_model

// [bench/sdram_refresh_sched_properties.sv]
// pin-level assertions on the refresh scheduler, bound to the top module
module sdram_refresh_sched_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic banksIdle,
    input wire logic cke,
    input wire logic csN,
    input wire logic [3:0] ca,
    input wire logic clockRun,
    input wire logic inSelfRefresh,
    input wire logic [2:0] bankPointer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    logic ab, pb, sre;
    logic [7:0] gapQ;
    logic [3:0] pbQ;
    logic okQ;

    // command decode from the pins
    assign ab = cke && !csN && ca == 4'hc;
    assign pb = cke && !csN && ca == 4'h4;
    assign sre = !cke && !csN && ca == 4'h4;

    // gap since last all-bank refresh; refresh seen since the last exit
    always_ff @(posedge clock) begin
        if (rst) begin
            gapQ <= 8'hff;
            pbQ <= 4'h0;
            okQ <= 1'b1;
        end else begin
            gapQ <= ab ? 8'h01 : gapQ + {7'h0, gapQ != 8'hff};
            if ($fell(inSelfRefresh) && !$past(rst)) begin
                pbQ <= 4'h0;
                okQ <= 1'b0;
            end else begin
                pbQ <= pbQ + {3'h0, pb && pbQ != 4'h8};
                okQ <= okQ || ab || pbQ == 4'h8;
            end
        end
    end

    a_sref_encode: assert property (
        $fell(cke) |-> sre && $past(banksIdle))
        else $error("entry badly encoded");
    a_sref_nop: assert property (
        sre |=> !cke && !csN && ca == 4'h7 ##1 !cke)
        else $error("no nop or cke after entry");
    a_exit_nops: assert property (
        $rose(cke) && !$past(rst)
        |-> (cke && !csN && ca == 4'h7) [*6])
        else $error("exit delay not nops");
    a_exit_clock: assert property (
        $rose(cke) && !$past(rst)
        |-> $past(clockRun) && $past(clockRun, 2))
        else $error("clock not stable before exit");
    a_ref_idle: assert property (
        cke && !csN && ca[2:0] == 3'h4 |-> $past(banksIdle))
        else $error("refresh with busy banks");
    a_burst_gap: assert property (ab |-> gapQ >= 8'h15)
        else $error("all-bank refreshes too close");
    a_ab_space: assert property (ab |=> (csN || ca == 4'h7) [*6])
        else $error("command inside all-bank cycle");
    a_pb_space: assert property (pb |=> (csN || ca == 4'h7) [*3])
        else $error("command inside per-bank cycle");
    a_exit_ptr: assert property (
        $fell(inSelfRefresh) && !$past(rst)
        |-> bankPointer == 3'h0)
        else $error("bank pointer kept over exit");
    a_ref_between: assert property (sre |-> okQ)
        else $error("entry without refresh since exit");

    c_entry: cover property (sre);
    c_perbank: cover property (pb);
    c_exit: cover property ($rose(cke));
endmodule : sdram_refresh_sched_properties

bind sdram_refresh_sched sdram_refresh_sched_properties u_props (
    .clock(clock),
    .rst(rst),
    .banksIdle(banksIdle),
    .cke(cke),
    .csN(csN),
    .ca(ca),
    .clockRun(clockRun),
    .inSelfRefresh(inSelfRefresh),
    .bankPointer(bankPointer)
);

// [bench/sdram_refresh_sched_tb_top.sv]
// self-checking bench for the refresh scheduler against a device model
module sdram_refresh_sched_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hotMode = 1'b0;
    logic perBankMode = 1'b0;
    logic banksIdle = 1'b1;
    logic selfRefreshReq = 1'b0;
    logic cke, csN, clockRun, userGrant, inSelfRefresh, refreshUrgent;
    logic [3:0] ca;
    logic [2:0] bankPointer, bankCnt;
    logic inSr;
    int abCnt, pbCnt, viol, base, exp;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hd9617244;

    always #12.5 clock = ~clock;

    sdram_refresh_sched u_dut (
        .clock(clock), .rst(rst), .hotMode(hotMode),
        .perBankMode(perBankMode), .banksIdle(banksIdle),
        .selfRefreshReq(selfRefreshReq), .cke(cke), .csN(csN), .ca(ca),
        .clockRun(clockRun), .userGrant(userGrant),
        .inSelfRefresh(inSelfRefresh), .refreshUrgent(refreshUrgent),
        .bankPointer(bankPointer)
    );

    sdram_device_model u_dev (
        .clock(clock), .rst(rst), .clockRun(clockRun), .cke(cke),
        .csN(csN), .ca(ca), .inSr(inSr), .bankCnt(bankCnt),
        .abCnt(abCnt), .pbCnt(pbCnt), .viol(viol)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // refreshes owed after a span, one per interval
    function automatic int owedFor(input int cyc, input int per);
        return cyc / per;
    endfunction : owedFor

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : step

    task automatic cmpCnt(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : cmpCnt

    task automatic cmpBit(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpBit

    task automatic test_done();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // hang guard: whole run needs about 11100 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        step(2);
        rst = 1'b0;
        step(1);
        cmpBit({2'h0, userGrant}, 3'h1);
        base = abCnt;
        step(3120);
        exp = owedFor(3120, 156);
        cmpCnt(abCnt - base, exp - 1, exp);
        $display("cool window done");
        hotMode = 1'b1;
        step(50);
        base = abCnt;
        step(1560);
        exp = owedFor(1560, 39);
        cmpCnt(abCnt - base, exp - 2, exp + 1);
        $display("hot window done");
        hotMode = 1'b0;
        perBankMode = 1'b1;
        step(200);
        base = pbCnt;
        step(1248);
        exp = 8 * owedFor(1248, 156);
        cmpCnt(pbCnt - base, exp - 8, exp + 8);
        $display("per-bank done");
        perBankMode = 1'b0;
        banksIdle = 1'b0;
        step(1112);
        cmpBit({2'h0, refreshUrgent}, 3'h1);
        banksIdle = 1'b1;
        base = abCnt;
        step(190);
        cmpCnt(abCnt - base, 7, 9);
        cmpBit({2'h0, refreshUrgent}, 3'h0);
        $display("catch-up burst done");
        selfRefreshReq = 1'b1;
        for (int i = 0; i < 400 && inSr !== 1'b1; i++) step(1);
        cmpBit({2'h0, inSr}, 3'h1);
        step(300);
        cmpBit({2'h0, userGrant}, 3'h0);
        base = abCnt;
        selfRefreshReq = 1'b0;
        for (int i = 0; i < 60 && inSelfRefresh !== 1'b0; i++) step(1);
        cmpBit({2'h0, inSelfRefresh}, 3'h0);
        cmpBit(bankPointer, 3'h0);
        cmpBit(bankCnt, 3'h0);
        selfRefreshReq = 1'b1;
        for (int i = 0; i < 100 && inSr !== 1'b1; i++) step(1);
        cmpCnt(abCnt - base, 1, 1);
        selfRefreshReq = 1'b0;
        step(60);
        $display("self refresh done");
        for (int i = 0; i < 3000; i++) begin
            seed = lfsr(seed);
            banksIdle = seed[0] | seed[1];
            if (seed[9:4] == 6'h00) selfRefreshReq = ~selfRefreshReq;
            if (seed[19:12] == 8'h00) hotMode = ~hotMode;
            if (seed[27:20] == 8'h00) perBankMode = ~perBankMode;
            step(1);
        end
        selfRefreshReq = 1'b0;
        banksIdle = 1'b1;
        step(200);
        cmpCnt(viol, 0, 0);
        $display("random traffic done");
        test_done();
    end
endmodule : sdram_refresh_sched_tb_top

// [core/credit_if.sv]
// link between the scheduler and the refresh credit counter
interface credit_if;
    logic hot;
    logic inSr;
    logic refDone;
    logic restart;
    logic [3:0] owed;
    logic urgent;

    modport sched (
        output hot,
        output inSr,
        output refDone,
        output restart,
        input owed,
        input urgent
    );

    modport credit (
        input hot,
        input inSr,
        input refDone,
        input restart,
        output owed,
        output urgent
    );
endinterface : credit_if

// [core/refresh_credit.sv]
// refresh credit counter: interval ticks owed, refreshes paid
`include "sdram_refresh_defs.svh"

module refresh_credit
    import sdram_refresh_pkg::*;
#(
    parameter logic [15:0] INTERVAL_COOL = 16'h009c,
    parameter logic [15:0] INTERVAL_HOT = 16'h0027
) (
    input wire logic clock,
    input wire logic rst,
    credit_if.credit cr
);

    credit_state_t q, d;
    logic [15:0] limit;
    logic tick;
    logic up;
    logic down;

    // interval divider and saturating owed count
    always_comb begin
        d = q;
        tick = 1'b0;
        limit = cr.hot ? INTERVAL_HOT : INTERVAL_COOL;
        if (cr.restart) begin
            // dropping the partial interval rounds the credit up
            d.divCnt = 16'h0000;
        end else if (!cr.inSr) begin
            // no ticks while in self refresh: that time is credited
            if (q.divCnt >= limit - 16'h0001) begin
                d.divCnt = 16'h0000;
                tick = 1'b1;
            end else begin
                d.divCnt = q.divCnt + 16'h0001;
            end
        end
        up = tick && (q.owed < `OWED_MAX);
        down = cr.refDone && (q.owed != 4'h0);
        if (up && !down) begin
            d.owed = q.owed + 4'h1;
        end else if (down && !up) begin
            d.owed = q.owed - 4'h1;
        end
        // registered so the top output comes straight from a flop
        d.urgent = d.owed >= `OWED_URGENT;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cr.owed = q.owed;
    assign cr.urgent = q.urgent;

endmodule : refresh_credit

// [core/sdram_refresh_defs.svh]
// timing, encoding and count constants for the refresh scheduler
`ifndef SDRAM_REFRESH_DEFS_SVH
`define SDRAM_REFRESH_DEFS_SVH

// system clock rate
`define CLK_MHZ 40

// least times round up to whole cycles
`define NS_TO_CYC_UP(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
// longest times round down to whole cycles
`define MS_TO_CYC_DN(ms) ((ms) * `CLK_MHZ * 1000)

// refresh_window_time, cool and hot case temperature
`define REFW_COOL_MS 32
`define REFW_HOT_MS 8
// required refresh commands per window, 2 Gb density
`define REF_COUNT 8192
// average_refresh_interval for reference, ns
`define REFI_NS 3900

// all_bank_refresh_cycle and per_bank_refresh_cycle, ns
`define RFCAB_NS 130
`define RFCPB_NS 60
// burst_refresh_window, ns, and all-bank commands allowed in it
`define REFBW_NS 4160
`define REFBW_MAX_AB 8

// min_self_refresh_residency and self_refresh_exit_delay, ns
`define SR_RESIDENCY_NS 15
`define SR_EXIT_NS 140
// stable clock cycles before the edge that registers clock enable high
`define CLK_STABLE_CYC 8'h02

// refresh credit limits
`define OWED_MAX 4'h8
`define OWED_URGENT 4'h6
// last bank of the per-bank round robin
`define BANK_LAST 3'h7

// command/address codes, bit 0 is CA0, chip select separate
`define CA_NOP 4'h7
`define CA_ALL_BANK_REF 4'hc
`define CA_PER_BANK_REF 4'h4
`define CA_SREF 4'h4

`endif

// [core/sdram_refresh_pkg.sv]
// types shared by the refresh scheduler and its credit counter
package sdram_refresh_pkg;

    // scheduler states, one-hot
    typedef enum logic [5:0] {
        S_IDLE    = 6'h01,
        S_RECOVER = 6'h02,
        S_SR_NOP  = 6'h04,
        S_SR_HOLD = 6'h08,
        S_SR_CLK  = 6'h10,
        S_SR_EXIT = 6'h20
    } sched_mode_t;

    // whole state of the scheduler
    typedef struct packed {
        sched_mode_t mode;
        logic cke;
        logic csN;
        logic [3:0] ca;
        logic clockRun;
        logic grant;
        logic inSr;
        logic refDone;
        logic restart;
        logic refSinceExit;
        logic [2:0] bankPtr;
        logic [7:0] timCnt;
        logic [7:0] gapCnt;
    } sched_state_t;

    // whole state of the credit counter
    typedef struct packed {
        logic [15:0] divCnt;
        logic [3:0] owed;
        logic urgent;
    } credit_state_t;

endpackage : sdram_refresh_pkg

// [core/sdram_refresh_sched.sv]
// host-side refresh and self-refresh scheduler for a low-power sdram
//
// Overview of operation
// - Issue the required all-bank refresh count within every rolling window.
// - Window needs 8192 refreshes, averaging one per 3.9 us.
// - Above 85 C the rolling window shrinks to 8 ms.
// - Eight per-bank refreshes may stand in for one all-bank refresh.
// - At most 8 all-bank refreshes per burst window; per-bank exempt.
// - Burst window is 4.16 us, four times eight 130 ns cycles.
// - Wait 60 ns after a per-bank refresh before further refreshes.
// - Self-refresh time reduces owed refreshes, rounded up per interval.
// - Regular pattern: one refresh per interval; self refresh any time.
// - Pattern changes must keep every rolling window at the minimum count.
// - Enter self refresh right after catching up; resume refreshing on exit.
// - Entry: CKE low, CS low, CA0/1 low, CA2 high; CKE high before.
// - NOP after the entry command, then hold clock enable low.
// - All banks idle before the self-refresh entry command.
// - Stay in self refresh at least the minimum residency time.
// - Clock may stop after entry; two stable cycles before exit edge.
// - During exit delay drive NOPs with clock enable high.
// - Exit delay starts at first edge after clock enable rises.
// - At least one refresh between self-refresh exit and next entry.
// - No refresh in power-down; its length must respect the window.
// - Refresh: CS low, CA0/1 low, CA2 high; CA3 picks all or per-bank.
// - Per-bank order 0..7; pointer clears on reset and self-refresh exit.
`include "sdram_refresh_defs.svh"

module sdram_refresh_sched
    import sdram_refresh_pkg::*;
#(
    parameter int REFW_COOL_CYCLES = `MS_TO_CYC_DN(`REFW_COOL_MS),
    parameter int REFW_HOT_CYCLES = `MS_TO_CYC_DN(`REFW_HOT_MS)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic hotMode,
    input wire logic perBankMode,
    input wire logic banksIdle,
    input wire logic selfRefreshReq,
    output logic cke,
    output logic csN,
    output logic [3:0] ca,
    output logic clockRun,
    output logic userGrant,
    output logic inSelfRefresh,
    output logic refreshUrgent,
    output logic [2:0] bankPointer
);

    // average interval in cycles: window over count, rounded down
    localparam logic [15:0] INTERVAL_COOL =
        16'(REFW_COOL_CYCLES / `REF_COUNT);
    localparam logic [15:0] INTERVAL_HOT =
        16'(REFW_HOT_CYCLES / `REF_COUNT);

    // recovery after each refresh kind, rounded up
    localparam logic [7:0] RFCAB_CYC = 8'(`NS_TO_CYC_UP(`RFCAB_NS));
    localparam logic [7:0] RFCPB_CYC = 8'(`NS_TO_CYC_UP(`RFCPB_NS));

    // least spacing of all-bank refreshes: burst window over its cap
    localparam logic [7:0] GAP_CYC =
        8'(`NS_TO_CYC_UP(`REFBW_NS / `REFBW_MAX_AB));

    // self-refresh residency and exit delay
    localparam logic [7:0] RESID_CYC = 8'(`NS_TO_CYC_UP(`SR_RESIDENCY_NS));
    localparam logic [7:0] EXIT_CYC = 8'(`NS_TO_CYC_UP(`SR_EXIT_NS));

    credit_if crl ();

    sched_state_t q, d;
    logic needRef;
    logic srEntryOk;

    refresh_credit #(
        .INTERVAL_COOL(INTERVAL_COOL),
        .INTERVAL_HOT(INTERVAL_HOT)
    ) u_credit (
        .clock(clock),
        .rst(rst),
        .cr(crl)
    );

    // a refresh is owed, or the one required since the last exit is missing
    always_comb begin
        needRef = ((crl.owed != 4'h0) || !q.refSinceExit) && banksIdle;
    end

    // entry only when caught up, so the pause follows a burst phase
    always_comb begin
        srEntryOk = selfRefreshReq && banksIdle
            && (crl.owed == 4'h0)
            && q.refSinceExit
            && q.cke;
    end

    // next state of the whole scheduler
    always_comb begin
        d = q;
        // deselect by default; single-cycle strobes fall back
        d.csN = 1'b1;
        d.ca = `CA_NOP;
        d.refDone = 1'b0;
        d.restart = 1'b0;
        if (q.timCnt != 8'h00) begin
            d.timCnt = q.timCnt - 8'h01;
        end
        // burst spacing keeps running in every state
        if (q.gapCnt != 8'h00) begin
            d.gapCnt = q.gapCnt - 8'h01;
        end

        unique case (q.mode)
            S_IDLE: begin
                d.cke = 1'b1;
                d.clockRun = 1'b1;
                if (srEntryOk) begin
                    // entry: clock enable falls with the refresh code
                    d.cke = 1'b0;
                    d.csN = 1'b0;
                    d.ca = `CA_SREF;
                    d.inSr = 1'b1;
                    d.timCnt = RESID_CYC;
                    d.mode = S_SR_NOP;
                end else if (needRef && perBankMode) begin
                    d.csN = 1'b0;
                    d.ca = `CA_PER_BANK_REF;
                    d.timCnt = RFCPB_CYC - 8'h01;
                    d.bankPtr = q.bankPtr + 3'h1;
                    // a full round of eight pays one all-bank refresh
                    if (q.bankPtr == `BANK_LAST) begin
                        d.refDone = 1'b1;
                        d.refSinceExit = 1'b1;
                    end
                    d.mode = S_RECOVER;
                end else if (needRef && (q.gapCnt == 8'h00)) begin
                    d.csN = 1'b0;
                    d.ca = `CA_ALL_BANK_REF;
                    d.timCnt = RFCAB_CYC - 8'h01;
                    d.gapCnt = GAP_CYC - 8'h01;
                    // all-bank refresh resynchronises the bank counter
                    d.bankPtr = 3'h0;
                    d.refDone = 1'b1;
                    d.refSinceExit = 1'b1;
                    d.mode = S_RECOVER;
                end
            end
            S_RECOVER: begin
                // nothing more to this device until the cycle time ends
                if (q.timCnt == 8'h00) begin
                    d.mode = S_IDLE;
                end
            end
            S_SR_NOP: begin
                // the cycle after entry carries a NOP
                d.cke = 1'b0;
                d.csN = 1'b0;
                d.ca = `CA_NOP;
                d.mode = S_SR_HOLD;
            end
            S_SR_HOLD: begin
                // pins are don't care to the device; keep them quiet
                d.cke = 1'b0;
                d.clockRun = 1'b0;
                if ((q.timCnt == 8'h00) && !selfRefreshReq) begin
                    // restart the clock ahead of the exit edge
                    d.clockRun = 1'b1;
                    d.timCnt = `CLK_STABLE_CYC;
                    d.mode = S_SR_CLK;
                end
            end
            S_SR_CLK: begin
                d.cke = 1'b0;
                if (q.timCnt == 8'h00) begin
                    // exit delay counts from the edge after this rise
                    d.cke = 1'b1;
                    d.csN = 1'b0;
                    d.ca = `CA_NOP;
                    d.timCnt = EXIT_CYC;
                    d.mode = S_SR_EXIT;
                end
            end
            S_SR_EXIT: begin
                d.cke = 1'b1;
                if (q.timCnt == 8'h00) begin
                    // no valid command before the delay ends
                    d.inSr = 1'b0;
                    d.restart = 1'b1;
                    d.bankPtr = 3'h0;
                    d.refSinceExit = 1'b0;
                    d.mode = S_IDLE;
                end else begin
                    d.csN = 1'b0;
                    d.ca = `CA_NOP;
                end
            end
            default: begin
                // an illegal one-hot code falls back to idle
                d.mode = S_IDLE;
            end
        endcase

        // the user may drive the bus only when no refresh is pressing;
        // power-down may still be granted while up to five refreshes are owed
        d.grant = (d.mode == S_IDLE) && !crl.urgent
            && !selfRefreshReq && q.refSinceExit;
    end

    // single register bank for the whole scheduler
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.mode <= S_IDLE;
            q.cke <= 1'b1;
            q.csN <= 1'b1;
            q.ca <= `CA_NOP;
            q.clockRun <= 1'b1;
            q.refSinceExit <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // credit link
    assign crl.hot = hotMode;
    assign crl.inSr = q.inSr;
    assign crl.refDone = q.refDone;
    assign crl.restart = q.restart;

    // outputs come straight from the state register
    assign cke = q.cke;
    assign csN = q.csN;
    assign ca = q.ca;
    assign clockRun = q.clockRun;
    assign userGrant = q.grant;
    assign inSelfRefresh = q.inSr;
    assign bankPointer = q.bankPtr;

    // urgency reflects a registered credit count
    assign refreshUrgent = crl.urgent;

endmodule : sdram_refresh_sched
